// >>> src/itd_pkg.sv
// Shared constants and carriers for the input terminal function decoder.
// Assumes a 32-bit APB slave port and four debounced digital terminals.
package itd_pkg;

  // Terminal count and counter width defaults.
  localparam int NUM_TERM = 4;
  localparam int CNT_W = 16;
  localparam int CODE_SPAN = 32;

  // Function codes, used as bit indices into the code hit vector.
  localparam int FN_NONE = 0;
  localparam int FN_FORWARD_RUN = 1;
  localparam int FN_REVERSE_RUN = 2;
  localparam int FN_THREE_WIRE = 3;
  localparam int FN_FORWARD_JOG = 4;
  localparam int FN_REVERSE_JOG = 5;
  localparam int FN_FREQ_UP = 6;
  localparam int FN_FREQ_DOWN = 7;
  localparam int FN_COAST = 8;
  localparam int FN_FAULT_RESET = 9;
  localparam int FN_RUN_PAUSE = 10;
  localparam int FN_EXT_FAULT = 11;
  localparam int FN_SPEED_B0 = 12;
  localparam int FN_SPEED_B3 = 15;
  localparam int FN_RAMP_B0 = 16;
  localparam int FN_RAMP_B1 = 17;
  localparam int FN_SRC_SWITCH = 18;
  localparam int FN_UPDOWN_CLEAR = 19;
  localparam int FN_CMD_SWITCH = 20;
  localparam int FN_RAMP_HOLD = 21;
  localparam int FN_PID_PAUSE = 22;
  localparam int FN_SEQ_RESET = 23;
  localparam int FN_RESERVED = 24;
  localparam int FN_COUNT_IN = 25;
  localparam int FN_COUNT_CLEAR = 26;
  localparam int FN_LENGTH_IN = 27;
  localparam int FN_PULSE_FREQ = 30;

  // Register byte offsets.
  localparam logic [11:0] OFS_FN_BASE = 12'h000;
  localparam logic [11:0] OFS_CMD = 12'h010;
  localparam logic [11:0] OFS_COUNT = 12'h014;
  localparam logic [11:0] OFS_LENGTH = 12'h018;
  localparam logic [11:0] OFS_CFG = 12'h01C;

  // Reset values; terminal a sits in the low byte.
  localparam logic [31:0] FN_RESET = 32'h0009_0201;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // Command source encodings.
  localparam logic [1:0] CS_KEYPAD = 2'h0;
  localparam logic [1:0] CS_TERMINAL = 2'h1;
  localparam logic [1:0] CS_COMM = 2'h2;

  // Software configuration word.
  typedef struct packed {
    logic dual_source;
    logic freq_digital;
    logic [1:0] cmd_source_setting;
  } itd_cfg_t;

  // Decoded drive commands, 28 bits.
  typedef struct packed {
    logic pulse_freq_edge;
    logic length_pulse;
    logic count_pulse;
    logic count_clear;
    logic simple_sequencer_reset;
    logic pid_pause;
    logic ramp_hold;
    logic [1:0] cmd_source;
    logic updown_clear;
    logic freq_src_b;
    logic [1:0] ramp_sel;
    logic [3:0] speed_sel;
    logic external_fault;
    logic run_pause;
    logic fault_reset;
    logic coast_stop;
    logic freq_down;
    logic freq_up;
    logic reverse_jog_cmd;
    logic forward_jog_cmd;
    logic three_wire;
    logic reverse_run_cmd;
    logic forward_run_cmd;
  } itd_cmd_t;

endpackage

// >>> src/itd_decoder.sv
// Input terminal function decoder with an APB register slave.
// Assumes terminal pins are asynchronous levels and are debounced outside.
//
// What this block does
// - Terminal set to code 0 yields no command at all.
// - Code 1 asserted requests forward run; code 2 requests reverse run.
// - Code 3 asserted selects three-wire operation for terminal run commands.
// - Code 4 requests forward jog; code 5 requests reverse jog.
// - Codes 6 and 7 raise or lower frequency, only with digital source.
// - Code 8 asserted blocks output so the motor coasts to standstill.
// - Code 9 clears the active fault like the keypad reset key.
// - Code 10 held pauses the run with state kept; release resumes.
// - Code 11 asserted raises external fault for the protection action.
// - Codes 12 to 15 form a four-bit multi-step selection.
// - Codes 16 and 17 form a two-bit ramp time set selection.
// - Code 18 picks one of two frequency sources when dual source is set.
// - Code 19 with digital source discards up/down offset back to preset.
// - Code 20 swaps terminal or communication source with the keypad.
// - Code 21 holds output frequency, ignoring all but stop.
// - Code 22 suspends the regulator and holds output frequency.
// - Code 23 returns the simple sequencer to its initial state.
// - Code 25 pulses increment the counter; code 26 clears it.
// - Code 27 pulses are counted by the length counter.
// - Code 30 makes a pulse input, accepted only on the fourth terminal.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module itd_decoder #(
  parameter int CNT_WIDTH = itd_pkg::CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_terminal_a,
  input wire logic input_terminal_b,
  input wire logic input_terminal_c,
  input wire logic high_speed_pulse_terminal,
  output itd_pkg::itd_cmd_t drive_cmd,
  output logic [CNT_WIDTH-1:0] count_value,
  output logic [CNT_WIDTH-1:0] length_value
);
  import itd_pkg::*;

  logic [NUM_TERM-1:0] term_meta;
  logic [NUM_TERM-1:0] term_sync;
  logic [NUM_TERM-1:0][7:0] fn;
  itd_cfg_t cfg;
  logic [CODE_SPAN-1:0] code_hit;
  logic [CODE_SPAN-1:0] hit_q;
  logic [CODE_SPAN-1:0] code_edge;
  itd_cmd_t next_cmd;
  logic [31:0] rd_data;
  logic rd_err;
  logic [1:0] fn_idx;
  logic fn_sel;
  logic acc_prep;
  logic wr_fire;
  logic fn_legal;

  // Two flops per pin; the first stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_meta <= '0;
      term_sync <= '0;
    end else begin
      term_meta <= {high_speed_pulse_terminal, input_terminal_c,
                    input_terminal_b, input_terminal_a};
      term_sync <= term_meta;
    end
  end

  // Collect which codes are asserted on any terminal. A code outside
  // the decoded span lights nothing, so reserved values stay silent.
  always_comb begin
    code_hit = '0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (term_sync[i] && fn[i] < 8'(CODE_SPAN)) begin
        // Pulse input only counts on the high-speed terminal.
        if (fn[i] != 8'(FN_PULSE_FREQ) || i == NUM_TERM - 1) begin
          code_hit[fn[i][4:0]] = 1'b1;
        end
      end
    end
    // Codes 0 and 24 never reach a command.
    code_hit[FN_NONE] = 1'b0;
    code_hit[FN_RESERVED] = 1'b0;
  end

  // Previous hits give rising edges for pulse style commands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_q <= '0;
    end else begin
      hit_q <= code_hit;
    end
  end

  assign code_edge = code_hit & ~hit_q;

  // Build the next command word from levels and edges.
  always_comb begin
    next_cmd = '0;
    next_cmd.forward_run_cmd = code_hit[FN_FORWARD_RUN];
    next_cmd.reverse_run_cmd = code_hit[FN_REVERSE_RUN];
    next_cmd.three_wire = code_hit[FN_THREE_WIRE];
    next_cmd.forward_jog_cmd = code_hit[FN_FORWARD_JOG];
    next_cmd.reverse_jog_cmd = code_hit[FN_REVERSE_JOG];
    next_cmd.freq_up = code_hit[FN_FREQ_UP] & cfg.freq_digital;
    next_cmd.freq_down = code_hit[FN_FREQ_DOWN] & cfg.freq_digital;
    next_cmd.coast_stop = code_hit[FN_COAST];
    // One pulse per press, like a single key stroke.
    next_cmd.fault_reset = code_edge[FN_FAULT_RESET];
    next_cmd.run_pause = code_hit[FN_RUN_PAUSE];
    // Sticky until a reset press; a held fault input wins.
    next_cmd.external_fault = code_hit[FN_EXT_FAULT] |
      (drive_cmd.external_fault & ~code_edge[FN_FAULT_RESET]);
    next_cmd.speed_sel = code_hit[FN_SPEED_B3:FN_SPEED_B0];
    next_cmd.ramp_sel = code_hit[FN_RAMP_B1:FN_RAMP_B0];
    next_cmd.freq_src_b = code_hit[FN_SRC_SWITCH] & cfg.dual_source;
    next_cmd.updown_clear = code_hit[FN_UPDOWN_CLEAR] &
      cfg.freq_digital;
    // Terminal or communication source yields to the keypad.
    if (code_hit[FN_CMD_SWITCH] &&
        (cfg.cmd_source_setting == CS_TERMINAL ||
         cfg.cmd_source_setting == CS_COMM)) begin
      next_cmd.cmd_source = CS_KEYPAD;
    end else begin
      next_cmd.cmd_source = cfg.cmd_source_setting;
    end
    next_cmd.ramp_hold = code_hit[FN_RAMP_HOLD];
    next_cmd.pid_pause = code_hit[FN_PID_PAUSE];
    next_cmd.simple_sequencer_reset = code_hit[FN_SEQ_RESET];
    next_cmd.count_clear = code_hit[FN_COUNT_CLEAR];
    next_cmd.count_pulse = code_edge[FN_COUNT_IN];
    next_cmd.length_pulse = code_edge[FN_LENGTH_IN];
    next_cmd.pulse_freq_edge = code_edge[FN_PULSE_FREQ];
  end

  // Registered command word so every output comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_cmd <= '0;
    end else begin
      drive_cmd <= next_cmd;
    end
  end

  // Event counter; a held clear wins over a pulse in the same cycle,
  // because clearing the count state is the stronger request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= '0;
    end else if (code_hit[FN_COUNT_CLEAR]) begin
      count_value <= '0;
    end else if (code_edge[FN_COUNT_IN]) begin
      count_value <= count_value + 1'b1;
    end
  end

  // Length counter; it wraps, since no length clear is decoded here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      length_value <= '0;
    end else if (code_edge[FN_LENGTH_IN]) begin
      length_value <= length_value + 1'b1;
    end
  end

  // APB timing: the access phase sees pready one cycle after entry.
  assign acc_prep = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite & ~pslverr;
  assign fn_sel = (paddr[11:4] == OFS_FN_BASE[11:4]);
  assign fn_idx = paddr[3:2];
  // Pulse input code is refused on the three ordinary terminals.
  assign fn_legal = (pwdata[7:0] != 8'(FN_PULSE_FREQ)) ||
                    (fn_idx == 2'(NUM_TERM - 1));

  // Read mux and error decision for the current address.
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end else if (fn_sel) begin
      rd_data = {24'h00_0000, fn[fn_idx]};
      rd_err = pwrite & pstrb[0] & ~fn_legal;
    end else if (paddr == OFS_CMD) begin
      rd_data = {4'h0, drive_cmd};
    end else if (paddr == OFS_COUNT) begin
      rd_data = 32'(count_value);
    end else if (paddr == OFS_LENGTH) begin
      rd_data = 32'(length_value);
    end else if (paddr == OFS_CFG) begin
      rd_data = {28'h000_0000, cfg};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Bus answer flops; read data is captured one cycle before completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= acc_prep;
      pslverr <= acc_prep & rd_err;
      if (acc_prep && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  // Function select registers; only byte lane 0 carries the code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fn <= FN_RESET;
    end else if (wr_fire && fn_sel && pstrb[0] && fn_legal) begin
      fn[fn_idx] <= pwdata[7:0];
    end
  end

  // Configuration word that steers gating of several commands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RESET;
    end else if (wr_fire && paddr == OFS_CFG && pstrb[0]) begin
      cfg <= pwdata[3:0];
    end
  end

  // Checks on the decoded behaviour.
  idle_codes_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_hit == '0) |=> (drive_cmd.forward_run_cmd == 1'b0 &&
    drive_cmd.speed_sel == 4'h0 && drive_cmd.coast_stop == 1'b0))
    else $error("idle codes raised a command");

  run_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_FORWARD_RUN] && !code_hit[FN_REVERSE_RUN] |=>
    drive_cmd.forward_run_cmd && !drive_cmd.reverse_run_cmd)
    else $error("forward run not decoded");

  updown_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg.freq_digital |=> !drive_cmd.freq_up && !drive_cmd.freq_down &&
    !drive_cmd.updown_clear)
    else $error("up down acted without digital source");

  reset_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    drive_cmd.fault_reset |=> !drive_cmd.fault_reset)
    else $error("fault reset longer than one cycle");

  fault_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    drive_cmd.external_fault && !code_hit[FN_FAULT_RESET] ##1
    !code_edge[FN_FAULT_RESET] |=> drive_cmd.external_fault)
    else $error("external fault dropped without reset");

  speed_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 drive_cmd.speed_sel == $past(code_hit[FN_SPEED_B3:FN_SPEED_B0]))
    else $error("speed selection mismatch");

  src_swap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_CMD_SWITCH] && cfg.cmd_source_setting == CS_COMM |=>
    drive_cmd.cmd_source == CS_KEYPAD)
    else $error("command source not swapped to keypad");

  count_step_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_edge[FN_COUNT_IN] && !code_hit[FN_COUNT_CLEAR] |=>
    count_value == $past(count_value) + 1'b1)
    else $error("counter did not step");

  pulse_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fn[0] != 8'(FN_PULSE_FREQ) && fn[1] != 8'(FN_PULSE_FREQ) &&
    fn[2] != 8'(FN_PULSE_FREQ))
    else $error("pulse code on ordinary terminal");

  pin_latency_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(term_sync[0]) && fn[0] == 8'(FN_COAST) ##1
    fn[0] == 8'(FN_COAST) |-> drive_cmd.coast_stop)
    else $error("coast not decoded from terminal a");

  // Commands and counters must follow their hit, edge or gate one cycle later.
  three_wire_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_THREE_WIRE] |=> drive_cmd.three_wire)
    else $error("three wire mode not decoded");

  fwd_jog_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_FORWARD_JOG] |=> drive_cmd.forward_jog_cmd)
    else $error("forward jog not decoded");

  rev_jog_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_REVERSE_JOG] |=> drive_cmd.reverse_jog_cmd)
    else $error("reverse jog not decoded");

  updown_pass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_FREQ_UP] && cfg.freq_digital |=> drive_cmd.freq_up)
    else $error("frequency up not decoded");

  coast_stop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_COAST] |=> drive_cmd.coast_stop)
    else $error("coast stop not decoded");

  fault_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_edge[FN_FAULT_RESET] |=> drive_cmd.fault_reset)
    else $error("fault reset press lost");

  run_pause_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_RUN_PAUSE] |=> drive_cmd.run_pause)
    else $error("run pause not decoded");

  fault_raise_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_EXT_FAULT] |=> drive_cmd.external_fault)
    else $error("external fault not raised");

  ramp_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 drive_cmd.ramp_sel == $past(code_hit[FN_RAMP_B1:FN_RAMP_B0]))
    else $error("ramp selection mismatch");

  src_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg.dual_source |=> !drive_cmd.freq_src_b)
    else $error("source switch without dual source");

  offset_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_UPDOWN_CLEAR] && cfg.freq_digital |=> drive_cmd.updown_clear)
    else $error("up down clear not decoded");

  ramp_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_RAMP_HOLD] |=> drive_cmd.ramp_hold)
    else $error("ramp hold not decoded");

  pid_pause_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_PID_PAUSE] |=> drive_cmd.pid_pause)
    else $error("regulator pause not decoded");

  seq_reset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_SEQ_RESET] |=> drive_cmd.simple_sequencer_reset)
    else $error("sequencer reset not decoded");

  count_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_hit[FN_COUNT_CLEAR] |=> count_value == '0)
    else $error("counter not cleared");

  length_step_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    code_edge[FN_LENGTH_IN] |=> length_value == $past(length_value) + 1'b1)
    else $error("length counter did not step");

endmodule

// >>> test/itd_contacts.sv
// Model of the switches and relay contacts wired to the four terminals.
// Assumes the bench sets the wanted contact state right after a clock edge.
`timescale 1ns/1ps
module itd_contacts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] closed,
  output logic [3:0] term
);
  // Contacts are open while reset is held, so no command can leak out.
  // Registering the contacts means pins never move in the sampling step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term <= 4'h0;
    end else begin
      term <= closed;
    end
  end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the terminal decoder and its APB registers.
// Assumes the contact model in itd_contacts.sv and the itd_pkg package.
`timescale 1ns/1ps
module tb_top;
  import itd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, closed, term;
  logic [15:0] count_value, length_value, c0;
  logic [3:0][7:0] code;
  itd_cmd_t drive_cmd;
  itd_cfg_t cfg;
  int err_total, checked, fr_seen, pf_seen, n, cp_seen, lp_seen, base;

  // Free-running 25 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  itd_decoder #(.CNT_WIDTH(16)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_terminal_a(term[0]),
    .input_terminal_b(term[1]), .input_terminal_c(term[2]),
    .high_speed_pulse_terminal(term[3]), .drive_cmd(drive_cmd),
    .count_value(count_value), .length_value(length_value));

  itd_contacts partner (.pclk(pclk), .presetn(presetn), .closed(closed),
    .term(term));

  // One-cycle pulses are counted here since a polled read would miss them.
  always @(posedge pclk) begin
    if (drive_cmd.fault_reset === 1'b1) fr_seen++;
    if (drive_cmd.pulse_freq_edge === 1'b1) pf_seen++;
    if (drive_cmd.count_pulse === 1'b1) cp_seen++;
    if (drive_cmd.length_pulse === 1'b1) lp_seen++;
  end

  task end_sim;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  // Pulses and the sticky fault are checked in their own scenarios.
  function automatic itd_cmd_t lvl(input itd_cmd_t x);
    x.fault_reset = 1'b0;
    x.count_pulse = 1'b0;
    x.length_pulse = 1'b0;
    x.pulse_freq_edge = 1'b0;
    x.external_fault = 1'b0;
    return x;
  endfunction

  task chk_cmd(input itd_cmd_t got, input itd_cmd_t exp);
    checked++;
    if (lvl(got) !== lvl(exp)) begin
      err_total++;
      $display("unexpected at %0t: cmd got %h exp %h", $time, got, exp);
    end
  endtask

  // Level commands expected from the codes, closed contacts and config.
  function automatic itd_cmd_t exp_cmd(input logic [3:0][7:0] c,
    input logic [3:0] p, input itd_cfg_t g);
    itd_cmd_t e;
    logic sw;
    e = '0;
    sw = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (p[k]) begin
        case (c[k])
          8'h01: e.forward_run_cmd = 1'b1;
          8'h02: e.reverse_run_cmd = 1'b1;
          8'h03: e.three_wire = 1'b1;
          8'h04: e.forward_jog_cmd = 1'b1;
          8'h05: e.reverse_jog_cmd = 1'b1;
          8'h06: e.freq_up |= g.freq_digital;
          8'h07: e.freq_down |= g.freq_digital;
          8'h08: e.coast_stop = 1'b1;
          8'h0A: e.run_pause = 1'b1;
          8'h0C, 8'h0D, 8'h0E, 8'h0F: e.speed_sel[c[k] - 8'h0C] = 1'b1;
          8'h10, 8'h11: e.ramp_sel[c[k] - 8'h10] = 1'b1;
          8'h12: e.freq_src_b |= g.dual_source;
          8'h13: e.updown_clear |= g.freq_digital;
          8'h14: sw = 1'b1;
          8'h15: e.ramp_hold = 1'b1;
          8'h16: e.pid_pause = 1'b1;
          8'h17: e.simple_sequencer_reset = 1'b1;
          8'h1A: e.count_clear = 1'b1;
          default: ; // Code 0, reserved codes, pulse codes and the sticky fault code 11.
        endcase
      end
    end
    e.cmd_source = g.cmd_source_setting;
    if (sw && g.cmd_source_setting != CS_KEYPAD) e.cmd_source = CS_KEYPAD;
    return e;
  endfunction

  // One APB transfer; the request is held until pready is seen high.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      err_total++;
      $display("unexpected at %0t: no pready", $time);
      end_sim();
    end
    @(posedge pclk);
  endtask

  // Contact flop, sync flops and command flop need four edges; six leave margin.
  task settle;
    repeat (6) @(posedge pclk);
  endtask

  task press(input int t, input int k);
    repeat (k) begin
      closed[t] <= 1'b1;
      settle();
      closed[t] <= 1'b0;
      settle();
    end
  endtask

  // A hung design still ends the run with a verdict.
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, closed} = '0;
    pstrb = 4'hF;
    presetn = 1'b0;
    {err_total, checked, fr_seen, pf_seen, cp_seen, lp_seen} = '0;
    void'($urandom(85314));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, (i < 4) ? 12'(i * 4) : OFS_CFG, 32'h0);
      chk(rd, (i < 4) ? {24'h0, FN_RESET[8 * i +: 8]} : 32'h0, "reset");
    end
    apb(1'b1, 12'h000, 32'h0000_001E);
    chk({31'h0, er}, 32'h1, "code 30 on a");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1, "a kept");
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped");
    apb(1'b0, 12'h002, 32'h0);
    chk({31'h0, er}, 32'h1, "misaligned");
    // First half sweeps every code on the fast terminal, then all random.
    for (int it = 0; it < 64; it++) begin
      cfg = itd_cfg_t'($urandom_range(0, 15));
      if (cfg.cmd_source_setting == 2'h3) cfg.cmd_source_setting = CS_COMM;
      for (int k = 0; k < 4; k++) begin
        code[k] = (it < 32) ? ((k == 3) ? 8'(it) : 8'h00) :
          8'($urandom_range(0, 31));
        if (k < 3 && code[k] == 8'h1E) code[k] = 8'h00;
        apb(1'b1, 12'(k * 4), {24'h0, code[k]});
      end
      apb(1'b1, OFS_CFG, {28'h0, cfg});
      closed <= 4'($urandom_range(0, 15)) | ((it < 32) ? 4'h8 : 4'h0);
      settle();
      chk_cmd(drive_cmd, exp_cmd(code, closed, cfg));
    end
    closed <= 4'h0;
    apb(1'b1, 12'h000, 32'h0000_000B);
    apb(1'b1, 12'h004, 32'h0000_0009);
    press(0, 1);
    chk({31'h0, drive_cmd.external_fault}, 32'h1, "fault sticky");
    n = fr_seen;
    press(1, 1);
    chk(32'(fr_seen - n), 32'h1, "reset pulse");
    chk({31'h0, drive_cmd.external_fault}, 32'h0, "fault cleared");
    apb(1'b1, 12'h000, 32'h0000_0019);
    apb(1'b1, 12'h004, 32'h0000_001A);
    apb(1'b1, 12'h008, 32'h0000_001B);
    apb(1'b1, 12'h00C, 32'h0000_001E);
    c0 = count_value;
    n = $urandom_range(2, 9);
    base = cp_seen;
    press(0, n);
    chk({16'h0, count_value}, {16'h0, 16'(c0 + n)}, "count");
    chk(32'(cp_seen - base), 32'(n), "count pulses");
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(rd, {16'h0, 16'(c0 + n)}, "count reg");
    press(1, 1);
    chk({16'h0, count_value}, 32'h0, "count clear");
    c0 = length_value;
    base = lp_seen;
    press(2, n);
    chk({16'h0, length_value}, {16'h0, 16'(c0 + n)}, "length");
    chk(32'(lp_seen - base), 32'(n), "length pulses");
    c0 = 16'(pf_seen);
    press(3, n);
    chk(32'(pf_seen - int'(c0)), 32'(n), "pulse input");
    end_sim();
  end
endmodule
